// *** pth_pkg.sv ***
/*
 * Shared constants for the tap threshold and time-limit core: register
 * offsets, field layouts, reset values and the base time step.
 * Assumes a single 20 MHz clock and an 8-bit host register port.
 */
`default_nettype none
package pth_pkg;

	// Register offsets on the host port
	localparam logic [7:0] ADDR_TAP_SRC       = 8'h22;
	localparam logic [7:0] ADDR_THRESHOLD_X   = 8'h23;
	localparam logic [7:0] ADDR_THRESHOLD_Y   = 8'h24;
	localparam logic [7:0] ADDR_THRESHOLD_Z   = 8'h25;
	localparam logic [7:0] ADDR_TIME_LIMIT    = 8'h26;
	localparam logic [7:0] ADDR_LATENCY       = 8'h27;

	// Field layout and reset values
	localparam int         THR_MSB            = 6;
	localparam logic [6:0] THR_RESET          = 7'h00;
	localparam logic [7:0] TIME_LIMIT_RESET   = 8'h00;
	localparam logic [7:0] LATENCY_RESET      = 8'h00;
	localparam logic [7:0] SRC_RESET          = 8'h00;
	localparam int         SRC_EA_BIT         = 7;
	localparam int         SRC_AXIS_LSB       = 4;
	localparam int         SRC_DPE_BIT        = 3;
	localparam int         SRC_POL_LSB        = 0;

	// One threshold count is 16 codes of a 12-bit sample at 8 g full scale
	localparam int         THR_SCALE_SHIFT    = 4;
	// Low-noise cap: 4 g expressed in 8 g-range sample codes
	localparam logic [10:0] THR_LOW_NOISE_CAP = 11'h400;

	// Full-scale selection codes
	localparam logic [1:0] FS_2G              = 2'h0;
	localparam logic [1:0] FS_4G              = 2'h1;

	// Oversampling mode codes
	localparam logic [1:0] MODE_NORMAL        = 2'h0;
	localparam logic [1:0] MODE_LN_LOW_POWER  = 2'h1;
	localparam logic [1:0] MODE_HIGH_RES      = 2'h2;
	localparam logic [1:0] MODE_LOW_POWER     = 2'h3;

	// Base time step (smallest step of all tables) and its cycle count
	localparam int         CLK_HZ             = 20000000;
	localparam int         BASE_STEP_NS       = 625000;
	localparam int         BASE_STEP_CYCLES   =
		BASE_STEP_NS / (1000000000 / CLK_HZ);
	localparam int         STEP_CNT_W         = 10;

endpackage
`default_nettype wire

// *** pth_cfg_if.sv ***
/*
 * Configuration carrier between the register file and the tap core.
 * Assumes both ends run on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface pth_cfg_if;
	logic [6:0] thrX;
	logic [6:0] thrY;
	logic [6:0] thrZ;
	logic [7:0] timeLimit;
	logic [7:0] latency;
	logic [7:0] srcStatus;
	logic       srcRead;

	modport regs (
		output thrX,
		output thrY,
		output thrZ,
		output timeLimit,
		output latency,
		output srcRead,
		input  srcStatus
	);
	modport core (
		input  thrX,
		input  thrY,
		input  thrZ,
		input  timeLimit,
		input  latency,
		input  srcRead,
		output srcStatus
	);
endinterface
`default_nettype wire

// *** pth_regs.sv ***
/*
 * Host-port register file for thresholds, time limit, latency and the
 * read-only tap source register.
 * Assumes single-cycle write and read strobes on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pth_regs
	import pth_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output var  logic [7:0] regRdData,
	pth_cfg_if.regs         cfg
);
	logic [6:0] thrX_q;
	logic [6:0] thrY_q;
	logic [6:0] thrZ_q;
	logic [7:0] timeLimit_q;
	logic [7:0] latency_q;
	logic [7:0] rdData_q;
	logic [7:0] rdData_d;

	// Writable registers; bit 7 of a threshold is never stored
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			thrX_q      <= THR_RESET;
			thrY_q      <= THR_RESET;
			thrZ_q      <= THR_RESET;
			timeLimit_q <= TIME_LIMIT_RESET;
			latency_q   <= LATENCY_RESET;
		end else if (regWr) begin
			case (regAddr)
				ADDR_THRESHOLD_X: thrX_q <= regWrData[THR_MSB:0];
				ADDR_THRESHOLD_Y: thrY_q <= regWrData[THR_MSB:0];
				ADDR_THRESHOLD_Z: thrZ_q <= regWrData[THR_MSB:0];
				ADDR_TIME_LIMIT:  timeLimit_q <= regWrData;
				ADDR_LATENCY:     latency_q <= regWrData;
				default: ;
			endcase
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		case (regAddr)
			ADDR_TAP_SRC:     rdData_d = cfg.srcStatus;
			ADDR_THRESHOLD_X: rdData_d = {1'b0, thrX_q};
			ADDR_THRESHOLD_Y: rdData_d = {1'b0, thrY_q};
			ADDR_THRESHOLD_Z: rdData_d = {1'b0, thrZ_q};
			ADDR_TIME_LIMIT:  rdData_d = timeLimit_q;
			ADDR_LATENCY:     rdData_d = latency_q;
			default:          rdData_d = 8'h00;
		endcase
	end

	// Read data is held until the next read strobe
	always_ff @(posedge ref_clk) begin
		if (rst)
			rdData_q <= 8'h00;
		else if (regRd)
			rdData_q <= rdData_d;
	end

	assign regRdData     = rdData_q;
	assign cfg.thrX      = thrX_q;
	assign cfg.thrY      = thrY_q;
	assign cfg.thrZ      = thrZ_q;
	assign cfg.timeLimit = timeLimit_q;
	assign cfg.latency   = latency_q;
	// Reading the source register clears it in the core
	assign cfg.srcRead   = regRd && (regAddr == ADDR_TAP_SRC);
endmodule
`default_nettype wire

// *** pth_tick.sv ***
/*
 * Step tick generator: a base prescaler plus a shared power-of-two
 * divider giving the time-limit tick and the latency tick.
 * Assumes stepShift is at most 8 so the latency shift fits the counter.
 */
`timescale 1ns/1ps
`default_nettype none
module pth_tick
	import pth_pkg::*;
#(
	parameter int BASE_CYCLES = BASE_STEP_CYCLES
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [3:0] stepShift,
	output var  logic       limitTick,
	output var  logic       latencyTick
);
	logic [15:0]           preCnt_q;
	logic                  baseTick;
	logic [STEP_CNT_W-1:0] divCnt_q;
	logic [STEP_CNT_W-1:0] limMask;
	logic [STEP_CNT_W-1:0] latMask;

	// Base prescaler, one pulse per base step
	always_ff @(posedge ref_clk) begin
		if (rst || baseTick)
			preCnt_q <= 16'h0000;
		else
			preCnt_q <= preCnt_q + 16'h0001;
	end
	assign baseTick = (preCnt_q == 16'(BASE_CYCLES - 1));

	// One free-running divider serves both ticks so they stay aligned
	always_ff @(posedge ref_clk) begin
		if (rst)
			divCnt_q <= '0;
		else if (baseTick)
			divCnt_q <= divCnt_q + 1'b1;
	end

	// Latency steps are twice the time-limit steps
	assign limMask = STEP_CNT_W'((1 << stepShift) - 1);
	assign latMask = STEP_CNT_W'((2 << stepShift) - 1);
	assign limitTick   = baseTick && ((divCnt_q & limMask) == limMask);
	assign latencyTick = baseTick && ((divCnt_q & latMask) == latMask);
endmodule
`default_nettype wire

// *** pth_top.sv ***
/*
 * Tap detector threshold and time-limit core: per-axis threshold
 * compare, pulse time-limit qualification, latency hold-off and the
 * clear-on-read tap source register with its interrupt level.
 * Assumes samples and mode settings come from logic on ref_clk and
 * that the host reaches registers through the 8-bit register port.
 */
`timescale 1ns/1ps
`default_nettype none
module pth_top
	import pth_pkg::*;
#(
	parameter int BASE_CYCLES = BASE_STEP_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output var  logic [7:0]  regRdData,
	input  wire logic        sampleValid,
	input  wire logic [11:0] accelX,
	input  wire logic [11:0] accelY,
	input  wire logic [11:0] accelZ,
	input  wire logic [2:0]  outputSampleRate,
	input  wire logic [1:0]  oversampleMode,
	input  wire logic        tapLowpassEnable,
	input  wire logic        lowNoiseEnable,
	input  wire logic [1:0]  fullScaleSel,
	output var  logic        tapIrq
);
	typedef enum logic [1:0] {
		AX_IDLE,
		AX_ABOVE,
		AX_EXPIRED
	} pth_axis_e;

	pth_cfg_if cfg ();

	logic [3:0]  stepShift;
	logic        limitTick;
	logic        latencyTick;
	logic [11:0] accel [3];
	logic [6:0]  thr [3];
	logic [2:0]  accepted;
	logic [2:0]  acceptPol;
	logic        latActive_q;
	logic [7:0]  latCnt_q;
	logic [7:0]  src_q;
	logic [7:0]  src_d;
	logic        irq_q;

	pth_regs u_regs (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.regAddr   (regAddr),
		.regWrData (regWrData),
		.regWr     (regWr),
		.regRd     (regRd),
		.regRdData (regRdData),
		.cfg       (cfg.regs)
	);

	// Step selection as a power of two of the 0.625 ms base step. The
	// filtered steps are not simply the unfiltered ones doubled: below 800 Hz
	// they stretch by four (in low-power mode only below 12.5 Hz), so each half has its
	// own entries rather than a shared table plus one.
	always_comb begin
		stepShift = 4'h0;
		if (!tapLowpassEnable) begin
			case (oversampleMode)
				MODE_HIGH_RES: stepShift = 4'h0;
				MODE_NORMAL: begin
					case (outputSampleRate)
						3'h0, 3'h1: stepShift = 4'h0;
						3'h2:       stepShift = 4'h1;
						3'h3:       stepShift = 4'h2;
						default:    stepShift = 4'h3; // 50 Hz and slower
					endcase
				end
				MODE_LN_LOW_POWER: begin
					case (outputSampleRate)
						3'h0, 3'h1: stepShift = 4'h0;
						3'h2:       stepShift = 4'h1;
						3'h3:       stepShift = 4'h2;
						3'h4:       stepShift = 4'h3;
						default:    stepShift = 4'h5; // 12.5 Hz and slower
					endcase
				end
				default: begin
					case (outputSampleRate)
						3'h0:    stepShift = 4'h0;
						3'h1:    stepShift = 4'h1;
						3'h2:    stepShift = 4'h2;
						3'h3:    stepShift = 4'h3;
						3'h4:    stepShift = 4'h4;
						default: stepShift = 4'h6; // 12.5 Hz and slower
					endcase
				end
			endcase
		end else begin
			case (oversampleMode)
				MODE_HIGH_RES: begin
					// 1.25 ms at 800 Hz, fixed 2.5 ms below it
					if (outputSampleRate == 3'h0)
						stepShift = 4'h1;
					else
						stepShift = 4'h2;
				end
				MODE_NORMAL: begin
					case (outputSampleRate)
						3'h0:    stepShift = 4'h1;
						3'h1:    stepShift = 4'h2;
						3'h2:    stepShift = 4'h3;
						3'h3:    stepShift = 4'h4;
						default: stepShift = 4'h5; // 50 Hz and slower
					endcase
				end
				MODE_LN_LOW_POWER: begin
					case (outputSampleRate)
						3'h0:    stepShift = 4'h1;
						3'h1:    stepShift = 4'h2;
						3'h2:    stepShift = 4'h3;
						3'h3:    stepShift = 4'h4;
						3'h4:    stepShift = 4'h5;
						default: stepShift = 4'h7; // 12.5 Hz and slower
					endcase
				end
				default: begin
					case (outputSampleRate)
						3'h0:    stepShift = 4'h1;
						3'h1:    stepShift = 4'h2;
						3'h2:    stepShift = 4'h3;
						3'h3:    stepShift = 4'h4;
						3'h4:    stepShift = 4'h5;
						3'h5:    stepShift = 4'h7;
						default: stepShift = 4'h8; // Longest step, 160 ms
					endcase
				end
			endcase
		end
	end

	pth_tick #(
		.BASE_CYCLES (BASE_CYCLES)
	) u_tick (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.stepShift   (stepShift),
		.limitTick   (limitTick),
		.latencyTick (latencyTick)
	);

	assign accel[0] = accelX;
	assign accel[1] = accelY;
	assign accel[2] = accelZ;
	assign thr[0]   = cfg.thrX;
	assign thr[1]   = cfg.thrY;
	assign thr[2]   = cfg.thrZ;

	// Per-axis threshold compare and time-limit qualification
	for (genvar a = 0; a < 3; a++) begin : g_axis
		pth_axis_e   state_q;
		logic [8:0]  tCnt_q;
		logic        pol_q;
		logic [11:0] mag;
		logic [10:0] mag8g;
		logic [10:0] thrEff;
		logic        exceed;
		logic        inLimit;

		// Magnitude of the two's-complement sample
		assign mag = accel[a][11] ? 12'(-accel[a]) : accel[a];

		// Rescale to the 8 g range so a count is always 0.063 g
		always_comb begin
			case (fullScaleSel)
				FS_2G:   mag8g = 11'(mag >> 2);
				FS_4G:   mag8g = 11'(mag >> 1);
				// Full negative scale has magnitude 2048; saturate it
				default: mag8g = mag[11] ? 11'h7ff : mag[10:0];
			endcase
		end

		// Unsigned code times 16 sample codes, capped in low-noise mode
		always_comb begin
			thrEff = {thr[a], 4'h0};
			if (lowNoiseEnable && thrEff > THR_LOW_NOISE_CAP)
				thrEff = THR_LOW_NOISE_CAP;
		end

		assign exceed  = mag8g > thrEff;
		// Count never passes 256 so 255 steps stay representable
		assign inLimit = tCnt_q <= {1'b0, cfg.timeLimit};

		// Qualification state; starts are ignored during latency
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				state_q <= AX_IDLE;
			end else begin
				case (state_q)
					AX_IDLE:
						if (sampleValid && exceed && !latActive_q)
							state_q <= AX_ABOVE;
					AX_ABOVE:
						if (sampleValid && !exceed)
							state_q <= AX_IDLE;
						else if (!inLimit)
							state_q <= AX_EXPIRED;
					AX_EXPIRED:
						// Too long a pulse must fall below before retrying
						if (sampleValid && !exceed)
							state_q <= AX_IDLE;
					default:
						state_q <= AX_IDLE;
				endcase
			end
		end

		// Step counter restarts on each new crossing
		always_ff @(posedge ref_clk) begin
			if (rst)
				tCnt_q <= 9'h000;
			else if (state_q == AX_IDLE)
				tCnt_q <= 9'h000;
			else if (limitTick && tCnt_q != 9'h100)
				tCnt_q <= tCnt_q + 9'h001;
		end

		// Polarity caught at the start of the crossing
		always_ff @(posedge ref_clk) begin
			if (rst)
				pol_q <= 1'b0;
			else if (state_q == AX_IDLE && sampleValid && exceed)
				pol_q <= accel[a][11];
		end

		// Falling below inside the limit accepts the pulse
		assign accepted[a]  = (state_q == AX_ABOVE) && sampleValid &&
			!exceed && inLimit;
		assign acceptPol[a] = pol_q;
	end

	// Latency hold-off after an accepted pulse, counted in latency steps
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			latActive_q <= 1'b0;
			latCnt_q    <= 8'h00;
		end else if (|accepted) begin
			latActive_q <= 1'b1;
			latCnt_q    <= 8'h00;
		end else if (latActive_q) begin
			if (latCnt_q >= cfg.latency)
				latActive_q <= 1'b0;
			else if (latencyTick)
				latCnt_q <= latCnt_q + 8'h01;
		end
	end

	// Source register: first event freezes it, a read clears it, and an
	// event in the clearing cycle wins so it is never lost
	always_comb begin
		src_d = src_q;
		if (cfg.srcRead)
			src_d = SRC_RESET;
		if (|accepted && !(src_q[SRC_EA_BIT] && !cfg.srcRead)) begin
			src_d = SRC_RESET;
			src_d[SRC_EA_BIT] = 1'b1;
			src_d[SRC_AXIS_LSB +: 3] = accepted;
			src_d[SRC_POL_LSB +: 3]  = accepted & acceptPol;
			src_d[SRC_DPE_BIT] = 1'b0; // Double tap is not built here
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			src_q <= SRC_RESET;
		else
			src_q <= src_d;
	end

	// Interrupt level follows the event-active flag
	always_ff @(posedge ref_clk) begin
		if (rst)
			irq_q <= 1'b0;
		else
			irq_q <= src_d[SRC_EA_BIT];
	end

	assign cfg.srcStatus = src_q;
	assign tapIrq        = irq_q;
endmodule
`default_nettype wire

// *** pth_top_asserts.sv ***
/*
 * Checker for pth_top: host port read rules and tap interrupt timing.
 * Assumes it is bound to pth_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module pth_top_asserts
	import pth_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWr,
	input wire logic       regRd,
	input wire logic [7:0] regRdData,
	input wire logic       sampleValid,
	input wire logic       tapIrq
);
	logic       srcRd;
	logic       thrAddr;
	logic       cntAddr;
	logic       mapped;
	logic [2:0] rdHist_q;
	logic [3:0] svHist_q;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Address classes on the host port
	assign srcRd   = regRd && regAddr == ADDR_TAP_SRC;
	assign thrAddr = regAddr inside {[ADDR_THRESHOLD_X:ADDR_THRESHOLD_Z]};
	assign cntAddr = regAddr inside {ADDR_TIME_LIMIT, ADDR_LATENCY};
	assign mapped  = thrAddr || cntAddr || regAddr == ADDR_TAP_SRC;

	// Recent reads and samples, so irq edges can be traced to a cause
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdHist_q <= 3'h0;
			svHist_q <= 4'h0;
		end else begin
			rdHist_q <= {rdHist_q[1:0], srcRd};
			svHist_q <= {svHist_q[2:0], sampleValid};
		end
	end

	sequence s_thr_wr_rd;
		regWr && thrAddr ##1 regRd && !regWr && $stable(regAddr);
	endsequence
	sequence s_cnt_wr_rd;
		regWr && cntAddr ##1 regRd && !regWr && $stable(regAddr);
	endsequence

	a_thr_readback: assert property (
		s_thr_wr_rd |=> regRdData == ($past(regWrData, 2) & 8'h7f))
		else $error("threshold readback wrong");
	a_cnt_readback: assert property (
		s_cnt_wr_rd |=> regRdData == $past(regWrData, 2))
		else $error("count register readback wrong");
	a_bit7_zero: assert property (
		regRd && thrAddr |=> !regRdData[7])
		else $error("threshold bit 7 read as one");
	a_unmapped_zero: assert property (
		regRd && !mapped |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	a_rd_hold: assert property (
		!$past(regRd) && !$past(rst) |-> $stable(regRdData))
		else $error("read data moved without a read");
	a_reset_clear: assert property (disable iff (1'b0)
		$past(rst) |-> !tapIrq && regRdData == 8'h00)
		else $error("reset left irq or read data set");
	// Irq may only fall shortly after a source read
	a_irq_stands: assert property (
		$fell(tapIrq) && !$past(rst) |-> rdHist_q != 3'h0)
		else $error("irq dropped without a source read");
	a_irq_clear: assert property (
		srcRd && !sampleValid |=> !tapIrq)
		else $error("irq still high after source read");
	a_irq_cause: assert property (
		$rose(tapIrq) |-> svHist_q != 4'h0)
		else $error("irq rose with no sample behind it");
endmodule

bind pth_top pth_top_asserts u_pth_top_asserts (
	.ref_clk, .rst, .regAddr, .regWrData, .regWr, .regRd,
	.regRdData, .sampleValid, .tapIrq
);
`default_nettype wire

// *** tb.sv ***
/*
 * Self-checking bench for pth_top: registers, time-limit steps,
 * thresholds, low-noise cap and latency hold-off.
 * Assumes the checker file binds itself to pth_top.
 */
`timescale 1ns/1ps
`default_nettype none
module tb
	import pth_pkg::*;
;
	// Short base step keeps even the longest step cheap to run
	localparam int          BASE = 4;
	// Step exponents per {lowpass, mode}, one nibble per rate code
	localparam logic [31:0] SH [8] = '{
		32'h33332100, 32'h55532100, 32'h00000000, 32'h66643210,
		32'h55554321, 32'h77754321, 32'h22222221, 32'h88754321};
	logic        ref_clk;
	logic        rst;
	logic [7:0]  regAddr;
	logic [7:0]  regWrData;
	logic        regWr;
	logic        regRd;
	logic [7:0]  regRdData;
	logic        sampleValid;
	logic [11:0] acc [3];
	logic [2:0]  outputSampleRate;
	logic [1:0]  oversampleMode;
	logic        tapLowpassEnable;
	logic        lowNoiseEnable;
	logic [1:0]  fullScaleSel;
	logic        tapIrq;
	logic        rdPend;
	logic        neg;
	logic [7:0]  d;
	logic [7:0]  e;
	logic [7:0]  expV;
	logic [7:0]  expQ [$];
	int          fail_count;
	int          n_checks;
	int          seed;
	int          t;
	int          ax;
	int          thr;
	int          fs;
	int          sh;

	pth_top #(.BASE_CYCLES(BASE)) u_pth_top (
		.ref_clk, .rst, .regAddr, .regWrData, .regWr, .regRd,
		.regRdData, .sampleValid, .accelX(acc[0]), .accelY(acc[1]),
		.accelZ(acc[2]), .outputSampleRate, .oversampleMode,
		.tapLowpassEnable, .lowNoiseEnable, .fullScaleSel, .tapIrq
	);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Read data lands one cycle after the strobe edge
	always @(posedge ref_clk) begin
		if (rdPend) begin
			expV = expQ.pop_front();
			chk(regRdData, expV);
		end
		rdPend <= regRd;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// Strobes rise and fall on falling edges, one cycle wide
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		regAddr = a;
		regWrData = v;
		regWr = 1'b1;
		cyc(1);
		regWr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		regAddr = a;
		regRd = 1'b1;
		expQ.push_back(x);
		cyc(1);
		regRd = 1'b0;
	endtask

	// Crossing sample, then a quiet sample dur cycles later
	task automatic tap(input int a, input logic [11:0] v, input int dur);
		acc[a] = v;
		sampleValid = 1'b1;
		cyc(1);
		sampleValid = 1'b0;
		acc[a] = 12'h000;
		cyc(dur - 1);
		sampleValid = 1'b1;
		cyc(1);
		sampleValid = 1'b0;
		cyc(3);
	endtask

	function automatic logic [7:0] src(input int a, input logic n);
		return 8'h80 | (8'h10 << a) | ({7'h00, n} << a);
	endfunction

	task automatic results();
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		seed = 22;
		fail_count = 0;
		n_checks = 0;
		rst = 1'b1;
		{regAddr, regWrData, regWr, regRd, rdPend} = '0;
		{sampleValid, acc[0], acc[1], acc[2]} = '0;
		{tapLowpassEnable, oversampleMode, outputSampleRate} = 6'h00;
		lowNoiseEnable = 1'b0;
		fullScaleSel = 2'h2;
		cyc(8);
		rst = 1'b0;
		cyc(1);
		for (int a = 8'h22; a < 8'h28; a++) begin
			rd(8'(a), 8'h00);
			cyc(1);
		end
		// Writes include the read-only source and an unmapped place
		for (int a = 8'h22; a < 8'h29; a++) begin
			d = 8'($random(seed)) | 8'h80;
			e = a inside {[8'h23:8'h25]} ? d & 8'h7f : d;
			if (a == 8'h22 || a == 8'h28)
				e = 8'h00;
			wr(8'(a), d);
			rd(8'(a), e);
		end
		wr(ADDR_THRESHOLD_X, 8'h01);
		cyc(1);
		wr(ADDR_TIME_LIMIT, 8'h02);
		cyc(1);
		wr(ADDR_LATENCY, 8'h00);
		// Limit 2: one step is kept, three steps are refused
		for (int m = 0; m < 64; m++) begin
			{tapLowpassEnable, oversampleMode, outputSampleRate} = 6'(m);
			t = BASE << ((SH[m / 8] >> (4 * (m % 8))) & 15);
			cyc(2 * t);
			tap(0, 12'h100, t);
			chk({7'h00, tapIrq}, 8'h01);
			rd(ADDR_TAP_SRC, 8'h90);
			cyc(1);
			chk({7'h00, tapIrq}, 8'h00);
			tap(0, 12'h100, 3 * t + 1);
			chk({7'h00, tapIrq}, 8'h00);
			rd(ADDR_TAP_SRC, 8'h00);
		end
		{tapLowpassEnable, oversampleMode, outputSampleRate} = 6'h00;
		wr(ADDR_TIME_LIMIT, 8'hff);
		cyc(8);
		tap(0, 12'h100, 254 * BASE);
		rd(ADDR_TAP_SRC, 8'h90);
		cyc(1);
		tap(0, 12'h100, 256 * BASE + 1);
		rd(ADDR_TAP_SRC, 8'h00);
		// Random axis, range and sign: one code over, then exactly at
		for (int i = 0; i < 12; i++) begin
			ax = {$random(seed)} % 3;
			thr = 1 + {$random(seed)} % 31;
			fs = {$random(seed)} % 4;
			neg = 1'($random(seed));
			sh = fs > 1 ? 0 : 2 - fs;
			fullScaleSel = 2'(fs);
			wr(8'(ADDR_THRESHOLD_X + ax), 8'(thr));
			tap(ax, 12'((neg ? -(thr * 16 + 1) : thr * 16 + 1) << sh), 4);
			rd(ADDR_TAP_SRC, src(ax, neg));
			cyc(1);
			tap(ax, 12'((neg ? -(thr * 16) : thr * 16) << sh), 4);
			rd(ADDR_TAP_SRC, 8'h00);
		end
		// Low-noise caps threshold 127 down to the 4 g code
		fullScaleSel = 2'h2;
		wr(ADDR_THRESHOLD_X, 8'h7f);
		lowNoiseEnable = 1'b1;
		tap(0, 12'h401, 4);
		rd(ADDR_TAP_SRC, 8'h90);
		cyc(1);
		tap(0, 12'h400, 4);
		rd(ADDR_TAP_SRC, 8'h00);
		lowNoiseEnable = 1'b0;
		tap(0, 12'h401, 4);
		rd(ADDR_TAP_SRC, 8'h00);
		// Latency 10: a quick second tap is ignored, a late one counts
		wr(ADDR_LATENCY, 8'h0a);
		tap(0, 12'h7ff, 4);
		rd(ADDR_TAP_SRC, 8'h90);
		cyc(1);
		tap(0, 12'h7ff, 4);
		rd(ADDR_TAP_SRC, 8'h00);
		cyc(24 * BASE);
		tap(0, 12'h7ff, 4);
		rd(ADDR_TAP_SRC, 8'h90);
		cyc(3);
		results();
	end
endmodule
`default_nettype wire
